// file: monitor_defines.svh
/*
  Named constants for the power monitor readback and status target.
  Assumes it is included by bare name wherever offsets or bit positions are needed.
*/
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH

// Command byte bit positions; bit 7 set marks an extended register pointer.
`define CMD_VOLT_CONT 0
`define CMD_VOLT_ONCE 1
`define CMD_CURR_CONT 2
`define CMD_CURR_ONCE 3
`define CMD_VDIV_SEL 4
`define CMD_STATUS_RD 6
`define CMD_EXT_FLAG 7
`define CMD_RESET 8'h00

// Extended register pointers held in the two low bits of the pointer byte.
`define EXT_ALERT_EN 2'h1
`define EXT_LIMIT 2'h2
`define EXT_CONTROL 2'h3

// Alert enable register fields.
`define AEN_OC_SINGLE 0
`define AEN_OC_FOUR 1
`define AEN_FAULT_NOTIFY 2
`define AEN_OFF_NOTIFY 3
`define AEN_CLEAR 4
`define AEN_RESET 8'h04

`define LIMIT_RESET 8'hff

// Synchroniser reset levels: fault low, power enable, data and clock high.
`define SYNC_IDLE 4'h7
`define CTRL_SHUTDOWN 0

// Status byte fields.
`define ST_CONV_OC_SEEN 0
`define ST_CONV_ALERT 1
`define ST_FAULT_NOW 2
`define ST_FAULT_LATCHED 3
`define ST_OFF_NOW 4
`define ST_OFF_ALERT 5

// Overcurrent run lengths, in conversions.
`define OC_RUN_SEEN 3'h3
`define OC_RUN_TRIP 3'h4

// Scale references, in tens of microvolts, for software use.
`define VOLT_FS_NARROW_10UV 665000
`define VOLT_FS_WIDE_10UV 2635000
`define CURR_FS_10UV 10584
`define CODE_SPAN 4096

`define BITS_PER_BYTE 4'h8
`define TARGET_ADDR_RESET 7'h50

`endif

// file: monitor_pkg.sv
/*
  Types shared by the monitor target modules.
  Assumes nothing of its surroundings.
*/
package monitor_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_WRITE = 7'h08,
    ST_WRITE_ACK = 7'h10,
    ST_READ = 7'h20,
    ST_READ_ACK = 7'h40
  } bus_state_t;

  typedef logic [7:0] byte_t;

endpackage

// file: line_events_if.sv
/*
  Synchronised bus line levels and edge events passed from the pin sampler
  to the protocol logic. Assumes both ends run on the system clock.
*/
`timescale 1ns/1ps
interface line_events_if;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic pwr_en;
  logic fault_now;

  modport sampler (output sda, scl_rise, scl_fall, start, stop, pwr_en, fault_now);
  modport consumer (input sda, scl_rise, scl_fall, start, stop, pwr_en, fault_now);
endinterface // line_events_if

// file: pin_sampler.sv
/*
  Two-flop synchronisers for all asynchronous pins and edge detection on the
  bus lines. Assumes the system clock is far faster than the bus clock.
*/
`timescale 1ns/1ps
`include "monitor_defines.svh"
module pin_sampler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic pwr_en_i,
  input wire logic fault_i,
  line_events_if.sampler ev
);
  import monitor_pkg::*;

  localparam int N = 4;
  // A fault line reset high would latch a false fault as reset lifts.
  localparam logic [N-1:0] IDLE_LEVELS = `SYNC_IDLE;
  logic [N-1:0] raw;
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;
  logic [1:0] last_reg;

  assign raw = {fault_i, pwr_en_i, sda_i, scl_i};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_reg[g] <= IDLE_LEVELS[g];
          sync_reg[g] <= IDLE_LEVELS[g];
        end else begin
          meta_reg[g] <= raw[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  // Edges come from the second stage against a third, never the first stage.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_reg <= 2'h3;
    end else begin
      last_reg <= sync_reg[1:0];
    end
  end

  assign ev.sda = sync_reg[1];
  assign ev.scl_rise = sync_reg[0] & ~last_reg[0];
  assign ev.scl_fall = ~sync_reg[0] & last_reg[0];
  assign ev.start = sync_reg[0] & last_reg[0] & last_reg[1] & ~sync_reg[1];
  assign ev.stop = sync_reg[0] & last_reg[0] & ~last_reg[1] & sync_reg[1];
  assign ev.pwr_en = sync_reg[2];
  assign ev.fault_now = sync_reg[3];
endmodule // pin_sampler

// file: oc_tracker.sv
/*
  Counts consecutive current conversions whose top eight bits exceed the
  limit. Assumes done_i is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`include "monitor_defines.svh"
module oc_tracker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic done_i,
  input wire logic [7:0] curr_top_i,
  input wire logic [7:0] limit_i,
  input wire logic en_single_i,
  input wire logic en_four_i,
  output logic seen_o,
  output logic trip_o
);
  import monitor_pkg::*;

  logic [2:0] run_reg;
  logic over;

  assign over = curr_top_i > limit_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_reg <= 3'h0;
    end else if (done_i) begin
      if (!over) begin
        run_reg <= 3'h0;
      end else if (run_reg != `OC_RUN_TRIP) begin
        run_reg <= run_reg + 3'h1;
      end
    end
  end

  assign seen_o = run_reg >= `OC_RUN_SEEN;

  // Trip is a one-cycle pulse on the conversion that meets an enabled condition.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trip_o <= 1'b0;
    end else begin
      trip_o <= done_i & over & (en_single_i |
                (en_four_i & (run_reg >= `OC_RUN_SEEN)));
    end
  end
endmodule // oc_tracker

// file: monitor_target.sv
/*
  Serial bus target of a power monitor: command and extended register writes,
  measurement readback in three packings, and the fault and shutdown status
  byte. Assumes an ADC outside delivers codes with one-cycle done pulses on
  the system clock, and that the open-drain SDA wire is resolved outside.
*/
`timescale 1ns/1ps
`include "monitor_defines.svh"
// Operation
// - Readback packing follows the configured channel mode.
// - Both channels: three bytes, nibbles shared.
// - Voltage only: two bytes, low nibble zero; single-shot reads follow done, which clears the bit, so they pack as both.
// - Current only: two bytes, low nibble zero; single-shot reads follow done, which clears the bit, so they pack as both.
// - Voltage code scales linearly with divider range.
// - Current code scales linearly with sense voltage.
// - Status byte read after address acknowledge.
// - Bit0 marks three consecutive overcurrent conversions.
// - Bit1 latches conversion overcurrent alert until clear.
// - Bit2 shows analog overcurrent switch-off state.
// - Bit3 latches insertion failure until clear.
// - Bit4 set when pin deasserted or shutdown.
// - Bit5 latches shutdown alert until clear.
// - Clear bit resets bits 1, 3, 5 only; with LATCH_OFF_VARIANT set, bit2 also drops because it follows the bit3 latch.
// - Single-shot nacks reads until conversion done.
// - Status-read bit returns status instead of data.
// - Limit compares top eight current bits, resets full.
module monitor_target #(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_RESET,
  parameter bit LATCH_OFF_VARIANT = 1'b1
) (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic POWER_ENABLE_PIN_I,
  input wire logic INSERTION_FAULT_NOW_I,
  input wire logic [11:0] VOLT_CODE_I,
  input wire logic VOLT_DONE_I,
  input wire logic [11:0] CURR_CODE_I,
  input wire logic CURR_DONE_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic VOLT_CONV_REQ_O,
  output logic CURR_CONV_REQ_O,
  output logic VOLTAGE_DIVIDER_SELECT_O,
  output logic SOFTWARE_SHUTDOWN_O
);
  import monitor_pkg::*;

  line_events_if ev ();

  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  monitor_pkg::byte_t rx_reg;
  monitor_pkg::byte_t tx_reg;
  logic rw_reg;
  logic [1:0] byte_idx_reg;
  logic [1:0] wr_cnt_reg;
  logic [1:0] ext_ptr_reg;
  logic ext_pending_reg;
  logic sda_oe_reg;
  monitor_pkg::byte_t cmd_reg;
  monitor_pkg::byte_t alert_en_reg;
  monitor_pkg::byte_t limit_reg;
  logic shutdown_reg;
  logic [11:0] volt_reg;
  logic [11:0] curr_reg;
  logic [11:0] volt_snap_reg;
  logic [11:0] curr_snap_reg;
  logic status_snap_reg;
  logic conv_alert_reg;
  logic fault_latched_reg;
  logic off_alert_reg;
  logic off_now_last_reg;
  logic fault_last_reg;
  logic conv_overcurrent_seen;
  logic conv_trip;
  logic clear_pulse;
  logic off_now;
  logic insertion_fault_now;
  logic once_pending;
  logic volt_sel;
  logic curr_sel;
  monitor_pkg::byte_t status_byte;
  monitor_pkg::byte_t wr_byte;
  logic byte_done;
  logic wr_byte_take;
  monitor_pkg::byte_t load_byte;

  pin_sampler u_sampler (
    .clk_i(SYS_CLK_I),
    .rst_n_i(ARST_N_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .pwr_en_i(POWER_ENABLE_PIN_I),
    .fault_i(INSERTION_FAULT_NOW_I),
    .ev(ev.sampler)
  );

  oc_tracker u_oc (
    .clk_i(SYS_CLK_I),
    .rst_n_i(ARST_N_I),
    .done_i(CURR_DONE_I),
    .curr_top_i(CURR_CODE_I[11:4]),
    .limit_i(limit_reg),
    .en_single_i(alert_en_reg[`AEN_OC_SINGLE]),
    .en_four_i(alert_en_reg[`AEN_OC_FOUR]),
    .seen_o(conv_overcurrent_seen),
    .trip_o(conv_trip)
  );

  // Picks one readback byte; a mode with no channel selected packs as both.
  function automatic monitor_pkg::byte_t pick_byte(input logic stat, input logic vs,
      input logic cs, input logic [1:0] idx, input logic [11:0] v, input logic [11:0] c,
      input monitor_pkg::byte_t st);
    monitor_pkg::byte_t b;
    b = 8'h00;
    if (stat) begin
      b = st;
    end else if (vs == cs) begin
      if (idx == 2'h0) begin
        b = v[11:4];
      end else if (idx == 2'h1) begin
        b = c[11:4];
      end else begin
        b = {v[3:0], c[3:0]};
      end
    end else if (vs) begin
      b = (idx == 2'h0) ? v[11:4] : {v[3:0], 4'h0};
    end else begin
      b = (idx == 2'h0) ? c[11:4] : {c[3:0], 4'h0};
    end
    return b;
  endfunction

  assign volt_sel = cmd_reg[`CMD_VOLT_CONT] | cmd_reg[`CMD_VOLT_ONCE];
  assign curr_sel = cmd_reg[`CMD_CURR_CONT] | cmd_reg[`CMD_CURR_ONCE];
  assign once_pending = cmd_reg[`CMD_VOLT_ONCE] | cmd_reg[`CMD_CURR_ONCE];
  assign insertion_fault_now = ev.fault_now;
  assign off_now = ~ev.pwr_en | shutdown_reg;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_CONV_OC_SEEN] = conv_overcurrent_seen;
    status_byte[`ST_CONV_ALERT] = conv_alert_reg;
    status_byte[`ST_FAULT_NOW] = LATCH_OFF_VARIANT ?
        (fault_latched_reg & alert_en_reg[`AEN_FAULT_NOTIFY]) : insertion_fault_now;
    status_byte[`ST_FAULT_LATCHED] = fault_latched_reg;
    status_byte[`ST_OFF_NOW] = off_now;
    status_byte[`ST_OFF_ALERT] = off_alert_reg;
  end

  assign byte_done = ev.scl_fall & (bit_cnt_reg == `BITS_PER_BYTE);
  assign wr_byte = rx_reg;
  assign wr_byte_take = (state_reg == ST_WRITE) & byte_done;
  // The next read byte; the index is zero while the address is acknowledged.
  assign load_byte = pick_byte(status_snap_reg, volt_sel, curr_sel, byte_idx_reg,
      volt_snap_reg, curr_snap_reg, status_byte);

  // Bus protocol sequencing; a start or stop anywhere overrides the state.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
      sda_oe_reg <= 1'b0;
    end else if (ev.start) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (ev.stop) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_WRITE: begin
          if (ev.scl_rise) begin
            rx_reg <= {rx_reg[6:0], ev.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done && state_reg == ST_WRITE) begin
            sda_oe_reg <= 1'b1;
            state_reg <= ST_WRITE_ACK;
          end else if (byte_done) begin
            // Single-shot readback is refused until its conversion lands.
            if (rx_reg[7:1] == TARGET_ADDR &&
                !(rx_reg[0] && once_pending && !cmd_reg[`CMD_STATUS_RD])) begin
              sda_oe_reg <= 1'b1;
              rw_reg <= rx_reg[0];
              byte_idx_reg <= 2'h0;
              state_reg <= ST_ADDR_ACK;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_WRITE_ACK: begin
          if (ev.scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg && state_reg == ST_ADDR_ACK) begin
              tx_reg <= load_byte << 1;
              sda_oe_reg <= ~load_byte[7];
              bit_cnt_reg <= 4'h1;
              state_reg <= ST_READ;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (byte_done) begin
            sda_oe_reg <= 1'b0;
            state_reg <= ST_READ_ACK;
          end else if (ev.scl_fall) begin
            sda_oe_reg <= ~tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        ST_READ_ACK: begin
          if (ev.scl_rise) begin
            // A not-acknowledge ends the read; the master then stops.
            if (ev.sda) begin
              state_reg <= ST_IDLE;
            end else if (byte_idx_reg != 2'h2) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end else if (ev.scl_fall) begin
            tx_reg <= load_byte << 1;
            sda_oe_reg <= ~load_byte[7];
            bit_cnt_reg <= 4'h1;
            state_reg <= ST_READ;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Results are frozen at the read address so one transfer stays coherent.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      volt_snap_reg <= 12'h000;
      curr_snap_reg <= 12'h000;
      status_snap_reg <= 1'b0;
    end else if (state_reg == ST_ADDR && byte_done) begin
      volt_snap_reg <= volt_reg;
      curr_snap_reg <= curr_reg;
      status_snap_reg <= cmd_reg[`CMD_STATUS_RD];
    end
  end

  // Codes are held raw; software applies the full-scale over code-span factor.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      volt_reg <= 12'h000;
      curr_reg <= 12'h000;
    end else begin
      if (VOLT_DONE_I) begin
        volt_reg <= VOLT_CODE_I;
      end
      if (CURR_DONE_I) begin
        curr_reg <= CURR_CODE_I;
      end
    end
  end

  // Write byte counting: first byte is a command or an extended pointer.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_cnt_reg <= 2'h0;
      ext_pending_reg <= 1'b0;
      ext_ptr_reg <= 2'h0;
    end else if (ev.start) begin
      wr_cnt_reg <= 2'h0;
      ext_pending_reg <= 1'b0;
    end else if (wr_byte_take) begin
      if (wr_cnt_reg != 2'h3) begin
        wr_cnt_reg <= wr_cnt_reg + 2'h1;
      end
      if (wr_cnt_reg == 2'h0 && wr_byte[`CMD_EXT_FLAG]) begin
        ext_pending_reg <= 1'b1;
        ext_ptr_reg <= wr_byte[1:0];
      end else begin
        ext_pending_reg <= 1'b0;
      end
    end
  end

  // Command register; a conversion done beats a rewrite of its once bit.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmd_reg <= `CMD_RESET;
    end else begin
      if (wr_byte_take && wr_cnt_reg == 2'h0 && !wr_byte[`CMD_EXT_FLAG]) begin
        cmd_reg <= wr_byte;
      end
      if (VOLT_DONE_I) begin
        cmd_reg[`CMD_VOLT_ONCE] <= 1'b0;
      end
      if (CURR_DONE_I) begin
        cmd_reg[`CMD_CURR_ONCE] <= 1'b0;
      end
    end
  end

  // Extended registers; the clear bit self-clears and is never stored.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      alert_en_reg <= `AEN_RESET;
      limit_reg <= `LIMIT_RESET;
      shutdown_reg <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      clear_pulse <= 1'b0;
      if (wr_byte_take && ext_pending_reg) begin
        if (ext_ptr_reg == `EXT_ALERT_EN) begin
          alert_en_reg <= wr_byte & ~(8'h01 << `AEN_CLEAR);
          clear_pulse <= wr_byte[`AEN_CLEAR];
        end else if (ext_ptr_reg == `EXT_LIMIT) begin
          limit_reg <= wr_byte;
        end else if (ext_ptr_reg == `EXT_CONTROL) begin
          shutdown_reg <= wr_byte[`CTRL_SHUTDOWN];
        end
      end
    end
  end

  // Sticky alerts: a new event in the clear cycle keeps its flag set.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      conv_alert_reg <= 1'b0;
      fault_latched_reg <= 1'b0;
      off_alert_reg <= 1'b0;
      off_now_last_reg <= 1'b0;
      fault_last_reg <= 1'b0;
    end else begin
      off_now_last_reg <= off_now;
      fault_last_reg <= insertion_fault_now;
      if (conv_trip) begin
        conv_alert_reg <= 1'b1;
      end else if (clear_pulse) begin
        conv_alert_reg <= 1'b0;
      end
      if (insertion_fault_now && alert_en_reg[`AEN_FAULT_NOTIFY]) begin
        fault_latched_reg <= 1'b1;
      end else if (clear_pulse) begin
        fault_latched_reg <= 1'b0;
      end
      if (off_now && !off_now_last_reg && alert_en_reg[`AEN_OFF_NOTIFY]) begin
        off_alert_reg <= 1'b1;
      end else if (clear_pulse) begin
        off_alert_reg <= 1'b0;
      end
    end
  end

  // Registered copies so every top output leaves a flip-flop.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      VOLT_CONV_REQ_O <= 1'b0;
      CURR_CONV_REQ_O <= 1'b0;
      VOLTAGE_DIVIDER_SELECT_O <= 1'b0;
      SOFTWARE_SHUTDOWN_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      SDA_OE_O <= sda_oe_reg;
      VOLT_CONV_REQ_O <= volt_sel;
      CURR_CONV_REQ_O <= curr_sel;
      VOLTAGE_DIVIDER_SELECT_O <= cmd_reg[`CMD_VDIV_SEL];
      SOFTWARE_SHUTDOWN_O <= shutdown_reg;
    end
  end
endmodule // monitor_target

// file: monitor_readback_and_status_properties.sv
/* Port-level assertions for the monitor target.
   Assumes a bind to monitor_target and sees only that module's ports. */
`timescale 1ns/1ps
module monitor_readback_and_status_properties #(
  parameter logic [6:0] TARGET_ADDR = 7'h50
) (
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic VOLT_DONE_I,
  input wire logic CURR_DONE_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic VOLT_CONV_REQ_O,
  input wire logic CURR_CONV_REQ_O,
  input wire logic VOLTAGE_DIVIDER_SELECT_O,
  input wire logic SOFTWARE_SHUTDOWN_O
);
  logic scl_q, sda_q, busy, foreign;
  logic [3:0] bits, vd_h, cd_h;
  logic [7:0] sh;
  wire logic st = SCL_I & scl_q & sda_q & !SDA_I;
  wire logic sp = SCL_I & scl_q & !sda_q & SDA_I;
  wire logic rise = SCL_I & !scl_q;
  wire logic fall = !SCL_I & scl_q;
  // Raw pins are watched, so the design's synchroniser delay is absorbed in the windows.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy <= 1'b0;
      foreign <= 1'b0;
      bits <= 4'h0;
      vd_h <= 4'h0;
      cd_h <= 4'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
      vd_h <= {vd_h[2:0], VOLT_DONE_I};
      cd_h <= {cd_h[2:0], CURR_DONE_I};
      busy <= st | (busy & !sp);
      bits <= st ? 4'h0 : bits + {3'h0, rise & (bits != 4'hf)};
      if (rise && bits < 4'h8) sh <= {sh[6:0], SDA_I};
      foreign <= !(st | sp) & (foreign | (fall & bits == 4'h8 & sh[7:1] != TARGET_ADDR));
    end
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_addr_write;
    fall && bits == 4'h8 && sh == {TARGET_ADDR, 1'b0};
  endsequence
  sequence s_ack_drive;
    ##[2:9] SDA_OE_O;
  endsequence
  a_sda_drive_low: assert property (SDA_O == 1'b0)
    else $error("data output driven high");
  a_oe_moves_low: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I))
    else $error("data drive changed while clock high");
  a_addr_ack_window: assert property (s_addr_write |-> s_ack_drive)
    else $error("own address not acknowledged in time");
  a_foreign_silent: assert property (foreign |-> !SDA_OE_O)
    else $error("data driven for a foreign address");
  a_vreq_drop_cause: assert property ($fell(VOLT_CONV_REQ_O) |-> busy || (|vd_h))
    else $error("voltage request dropped without cause");
  a_creq_drop_cause: assert property ($fell(CURR_CONV_REQ_O) |-> busy || (|cd_h))
    else $error("current request dropped without cause");
  a_range_idle_stable: assert property (!busy |=> $stable(VOLTAGE_DIVIDER_SELECT_O))
    else $error("divider select moved while bus idle");
  a_off_idle_stable: assert property (!busy |=> $stable(SOFTWARE_SHUTDOWN_O))
    else $error("shutdown moved while bus idle");
endmodule // monitor_readback_and_status_properties

// file: bus_master_model.sv
/* Serial bus master model: drives the clock and pulls the data wire low.
   Assumes a pull-up on the data wire and the bench clock as timebase. */
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Low phase length; raising it gives a slow master.
  int lo = 5;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wait_q(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_low_o = 1'b1;
    wait_q(10);
    scl_o = 1'b0;
    wait_q(lo);
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    wait_q(lo);
    scl_o = 1'b1;
    wait_q(10);
    sda_low_o = 1'b0;
    wait_q(10);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic r);
    for (int i = 8; i >= 0; i--) begin
      sda_low_o = (i > 0) ? !d[i - 1] : !last;
      wait_q(lo);
      scl_o = 1'b1;
      wait_q(10);
      if (i > 0) q[i - 1] = sda_i;
      else r = sda_i;
      scl_o = 1'b0;
      wait_q(5);
    end
  endtask
endmodule // bus_master_model

// file: monitor_readback_and_status_tb.sv
/* Self-checking bench for the monitor target with a bus master model.
   Assumes the package, design, master model and checker are compiled first. */
`timescale 1ns/1ps
module monitor_readback_and_status_tb;
  import monitor_pkg::*;
  localparam logic [6:0] ADDR = 7'h2c;
  localparam logic [7:0] RD = {ADDR, 1'b1};
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b1, fault = 1'b0, vdone = 1'b0, cdone = 1'b0;
  logic [11:0] vcode = 12'h000, ccode = 12'h000;
  logic scl, low, sda_o, sda_oe, vreq, creq, vsel, software_shutdown;
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & !low;
  int errors = 0, checks_done = 0, seed = 32'hbf0e;
  int cmd = 0, aen = 4, lim = 255, ctl = 0, mv = 0, mc = 0, run = 0;
  int seen = 0, calert = 0, flat = 0, offal = 0, offp = 0;
  byte_t q[$], e[$];
  byte_t modes[4] = '{8'h05, 8'h05, 8'h11, 8'h04};
  always #2 clk = !clk;
  bus_master_model m (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(low));
  monitor_target #(.TARGET_ADDR(ADDR)) uut (
    .SYS_CLK_I(clk), .ARST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda_w),
    .POWER_ENABLE_PIN_I(pwr), .INSERTION_FAULT_NOW_I(fault),
    .VOLT_CODE_I(vcode), .VOLT_DONE_I(vdone), .CURR_CODE_I(ccode), .CURR_DONE_I(cdone),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .VOLT_CONV_REQ_O(vreq), .CURR_CONV_REQ_O(creq),
    .VOLTAGE_DIVIDER_SELECT_O(vsel), .SOFTWARE_SHUTDOWN_O(software_shutdown));
  task automatic chk(input byte_t got, input byte_t exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: byte %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: bit %b wanted %b", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic upd();
    int off;
    off = !pwr || ctl[0];
    if (fault && aen[2]) flat = 1;
    if (off && !offp && aen[3]) offal = 1;
    offp = off;
  endtask
  function automatic byte_t stat();
    int off;
    off = !pwr || ctl[0];
    return {2'b00, offal[0], off[0], flat[0], flat[0] & aen[2], calert[0], seen[0]};
  endfunction
  function automatic void pack();
    logic vs, cs;
    vs = cmd[0] | cmd[1];
    cs = cmd[2] | cmd[3];
    if (vs && !cs) e = '{mv[11:4], {mv[3:0], 4'h0}};
    else if (cs && !vs) e = '{mc[11:4], {mc[3:0], 4'h0}};
    else e = '{mv[11:4], mc[11:4], {mv[3:0], mc[3:0]}};
  endfunction
  task automatic xact(input byte_t a, input int n, input byte_t w0, input byte_t w1,
                      output logic ack);
    logic [7:0] d;
    logic r;
    q.delete();
    m.start();
    m.xfer(a, 1'b1, d, r);
    ack = !r;
    for (int i = 0; i < n && ack; i++) begin
      m.xfer(a[0] ? 8'hff : (i > 0 ? w1 : w0), !a[0] || i == n - 1, d, r);
      q.push_back(d);
    end
    m.stop();
  endtask
  task automatic wr(input byte_t w0, input byte_t w1, input int n);
    logic ack;
    xact({ADDR, 1'b0}, n, w0, w1, ack);
    chk_bit(ack, 1'b1);
    if (!w0[7]) cmd = w0;
    else if (w0[1:0] == 2'h2) lim = w1;
    else if (w0[1:0] == 2'h3) ctl = w1;
    else begin
      aen = w1 & 8'h0f;
      if (w1[4]) {calert, flat, offal} = 0;
    end
    upd();
  endtask
  task automatic conv(input logic [11:0] v, input logic [11:0] c);
    logic over;
    {vcode, ccode, vdone, cdone} = {v, c, 2'b11};
    @(posedge clk);
    #1;
    {vdone, cdone} = 2'b00;
    @(posedge clk);
    #1;
    over = c[11:4] > lim;
    if (over && (aen[0] || (aen[1] && run >= 3))) calert = 1;
    run = over ? run + 1 : 0;
    seen = run >= 3;
    mv = v;
    mc = c;
    cmd = cmd & ~32'h0a;
  endtask
  task automatic rd_data();
    logic ack;
    pack();
    xact(RD, e.size(), 8'h00, 8'h00, ack);
    chk_bit(ack, 1'b1);
    foreach (e[k]) chk(q[k], e[k]);
  endtask
  task automatic rd_stat();
    logic ack;
    xact(RD, 1, 8'h00, 8'h00, ack);
    chk_bit(ack, 1'b1);
    chk(q[0], stat());
  endtask
  initial begin
    logic ack;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    xact({ADDR ^ 7'h01, 1'b1}, 1, 8'h00, 8'h00, ack);
    chk_bit(ack, 1'b0);
    // The first pass reads before any conversion, so all-zero data is expected.
    for (int i = 0; i < 4; i++) begin
      m.lo = i[0] ? 12 : 5;
      wr(modes[i], 8'h00, 1);
      if (i > 0) conv(12'($random(seed)), 12'($random(seed)));
      rd_data();
      chk_bit(vsel, cmd[4]);
      chk_bit(vreq, cmd[0] | cmd[1]);
      chk_bit(creq, cmd[2] | cmd[3]);
    end
    $display("test modes done");
    wr(8'h0a, 8'h00, 1);
    chk_bit(vreq, 1'b1);
    xact(RD, 1, 8'h00, 8'h00, ack);
    chk_bit(ack, 1'b0);
    conv(12'($random(seed)), 12'($random(seed)));
    chk_bit(creq, 1'b0);
    rd_data();
    $display("test single shot done");
    wr(8'h82, 8'h80, 2);
    wr(8'h81, 8'h0e, 2);
    wr(8'h44, 8'h00, 1);
    // The first code equals the limit; only the fourth over-limit code trips.
    for (int i = 0; i < 5; i++) begin
      conv(12'($random(seed)), {i > 0 ? 8'h81 : 8'h80, 4'h5});
      if (i > 2) rd_stat();
    end
    {fault, pwr} = 2'b10;
    upd();
    rd_stat();
    {fault, pwr} = 2'b01;
    upd();
    rd_stat();
    wr(8'h81, 8'h1d, 2);
    rd_stat();
    conv(12'($random(seed)), 12'hff0);
    wr(8'h83, 8'h01, 2);
    rd_stat();
    chk_bit(software_shutdown, 1'b1);
    $display("test status done");
    print_verdict();
  end
  initial begin
    #300000;
    errors++;
    print_verdict();
  end
endmodule // monitor_readback_and_status_tb
bind monitor_target monitor_readback_and_status_properties #(.TARGET_ADDR(TARGET_ADDR)) props (
  .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .VOLT_DONE_I(VOLT_DONE_I), .CURR_DONE_I(CURR_DONE_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .VOLT_CONV_REQ_O(VOLT_CONV_REQ_O), .CURR_CONV_REQ_O(CURR_CONV_REQ_O),
  .VOLTAGE_DIVIDER_SELECT_O(VOLTAGE_DIVIDER_SELECT_O),
  .SOFTWARE_SHUTDOWN_O(SOFTWARE_SHUTDOWN_O));
